// ### cis_ctrl.sv
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
// Function
// - current link follows d2 packet source
// - low line waits for matching stack
// - rt/nmi on rt stack, low on chosen
// - atomic stretch up to 256 packets
// - nonzero countdown blocks rt and low
// - nmi not blocked by countdown, resets it
// - line flag set on take, cleared exit
// - nested flags stay until all serviced
// - record origin of protected return
// - handler priority for rt/low handlers
// - state codes main low rt nmi
// - handler state exported to aggregator
// - low accepted only when enable set or supervisor
// - low take clears accept enable
// - record caller link of function
// - only same or higher lines nest in lower
// - nothing nests inside nmi handler
// - countdown delays rt/low in every state, not nmi
// - atomic op loads 8-bit, packets count
// - ops set and clear accept enable
// - supervisor low ignores accept enable
module cis_ctrl
  import cis_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avmAddress,
  input  wire logic        avmRead,
  input  wire logic        avmWrite,
  input  wire logic [31:0] avmWritedata,
  output logic      [31:0] avmReaddata,
  output logic             avmWaitrequest,
  input  cis_pipe_type     pipe,
  input  cis_req_type      req,
  output cis_ack_type      ack,
  output cis_link_type     aggr
);
  // bus slave
  logic        waitReq_r;      // waitrequest, high when idle
  logic [31:0] rdData_r;       // read data register
  wire         busReq;         // any request present
  wire         busTake;        // request sampled this edge
  wire         wrTake;         // write taking effect
  wire         selDsts;        // decode status selected
  wire         selCfg;         // config word selected
  logic [31:0] rdMux;          // read selection

  // status state
  logic [LINK_W-1:0]  curLink_r;   // link of d2 packet
  logic [LINK_W-1:0]  retLink_r;   // protected return origin
  logic [LINK_W-1:0]  callLink_r;  // caller origin
  logic [STK_W-1:0]   curStack_r;  // active stack index
  logic [STK_W-1:0]   lowStack_r;  // stack for low line
  logic [DEPTH_W-1:0] warn_r;      // nesting warning level
  logic [ATOM_W-1:0]  atom_r;      // atomic countdown
  logic [ATOM_W-1:0]  atom_nxt;
  logic               low_prio_accept_enable_r;      // low accept enable
  logic               low_prio_accept_enable_nxt;
  cis_state_type      state_r;     // handler state
  cis_state_type      state_nxt;
  logic [PRIO_W-1:0]  prio_r;      // handler priority
  logic [PRIO_W-1:0]  prio_nxt;

  // nesting bookkeeping
  logic [DEPTH_W-1:0] depth_r;     // slots in use
  logic [DEPTH_W-1:0] rtPtr_r;     // rt stack frames, rt plus nmi
  logic [DEPTH_W-1:0] lowCnt_r;    // nested low handlers
  logic [DEPTH_W-1:0] rtCnt_r;     // nested rt handlers
  logic               nonmaskable_line_flag_r;      // nmi handler active
  logic               settle_r;    // stack read catching up
  cis_ack_type        ack_r;       // take pulses
  cis_entry_type      topEntry;    // saved context on top
  cis_entry_type      pushEntry;   // context being saved

  // decisions
  wire atomZero;     // countdown expired
  wire stackRoom;    // a free nesting slot
  wire quiet;        // no stack update in flight
  wire nmiOk;
  wire rtOk;
  wire lowOk;
  wire takeNmi;
  wire takeRt;
  wire takeLow;
  wire anyTake;
  wire popEv;        // handler exit retiring
  wire lowEnabled;   // enable or supervisor override

  // bus slave: one wait state per access
  assign busReq  = avmRead | avmWrite;
  // waitrequest low for one cycle marks the taking edge
  assign busTake = busReq & ~waitReq_r;
  assign wrTake  = avmWrite & busTake;
  assign selDsts = avmAddress == ADDR_DECODE_PHASE_STATUS_WORD;
  assign selCfg  = avmAddress == ADDR_CFG;

  // read selection, unmapped offsets read zero
  always_comb begin
    rdMux = '0;
    case (avmAddress)
      ADDR_INTERRUPT_STATUS_WORD: begin
        // plain view, no read side effect
        rdMux[INTERRUPT_STATUS_WORD_LINK_LSB +: LINK_W]  = curLink_r;
        rdMux[INTERRUPT_STATUS_WORD_LOW_PRIO_STACK_SELECT_LSB +: STK_W]  = lowStack_r;
        rdMux[INTERRUPT_STATUS_WORD_CURSP_LSB +: STK_W]  = curStack_r;
        rdMux[INTERRUPT_STATUS_WORD_ATOM_LSB +: ATOM_W]  = atom_r;
        rdMux[INTERRUPT_STATUS_WORD_NONMASKABLE_LINE_FLAG_BIT]            = nonmaskable_line_flag_r;
        rdMux[INTERRUPT_STATUS_WORD_RTF_BIT]             = rtCnt_r != '0;
        rdMux[INTERRUPT_STATUS_WORD_LOWF_BIT]            = lowCnt_r != '0;
      end
      ADDR_DECODE_PHASE_STATUS_WORD: begin
        rdMux[DECODE_PHASE_STATUS_WORD_RETURN_ORIGIN_LINK_LSB +: LINK_W] = retLink_r;
        rdMux[DECODE_PHASE_STATUS_WORD_PRIO_LSB +: PRIO_W]  = prio_r;
        rdMux[DECODE_PHASE_STATUS_WORD_STATE_LSB +: 2]      = state_r;
        rdMux[DECODE_PHASE_STATUS_WORD_LOW_PRIO_ACCEPT_ENABLE_BIT]            = low_prio_accept_enable_r;
        rdMux[DECODE_PHASE_STATUS_WORD_CALLER_ORIGIN_LINK_LSB +: LINK_W] = callLink_r;
      end
      ADDR_CFG: begin
        rdMux[CFG_WARN_LSB +: DEPTH_W]  = warn_r;
        rdMux[CFG_LOW_PRIO_STACK_SELECT_LSB +: STK_W]   = lowStack_r;
      end
      ADDR_STK: begin
        rdMux[STK_PTR_LSB +: DEPTH_W]   = rtPtr_r;
        rdMux[STK_CEIL_LSB +: DEPTH_W]  = CEIL_LEVEL;
      end
      default: begin
        rdMux = '0;
      end
    endcase
  end

  // handshake register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitReq_r <= 1'b1;
      rdData_r  <= '0;
    end else begin
      waitReq_r <= !(busReq && waitReq_r);
      // data loaded while waitrequest is high
      if (avmRead && waitReq_r) begin
        rdData_r <= rdMux;
      end
    end
  end

  // software configuration; interrupt status word writes ignored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      warn_r     <= WARN_RST;
      lowStack_r <= LOW_PRIO_STACK_SELECT_RST;
    end else if (wrTake && selCfg) begin
      warn_r     <= avmWritedata[CFG_WARN_LSB +: DEPTH_W];
      // low line stack choice
      lowStack_r <= avmWritedata[CFG_LOW_PRIO_STACK_SELECT_LSB +: STK_W];
    end
  end

  // link tracking
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      curLink_r  <= LINK_RST;
      retLink_r  <= LINK_RST;
      callLink_r <= LINK_RST;
      curStack_r <= '0;
    end else begin
      // link of the packet now in d2
      curLink_r  <= pipe.d2Link;
      curStack_r <= pipe.curStack;
      if (pipe.protReturn) begin
        retLink_r <= pipe.returnLink;
      end
      // calls from handlers count as well
      if (pipe.callMade) begin
        callLink_r <= pipe.callerLink;
      end
    end
  end

  // acceptance
  assign atomZero   = atom_r == '0;
  assign stackRoom  = depth_r != NEST_FULL;
  // an exit or a fresh push keeps the top entry stale
  assign quiet      = !settle_r && !pipe.handlerExit;
  // supervisor requests bypass the enable
  assign lowEnabled = low_prio_accept_enable_r || req.lowSupervisor;

  // nmi ignores the countdown, never inside nmi
  assign nmiOk = req.nmiReq && state_r != CIS_NMI
               && stackRoom && quiet;
  // rt may nest in main, low or rt
  assign rtOk  = req.rtReq && state_r != CIS_NMI
               && atomZero
               && stackRoom && quiet;
  // low nests only in main or low
  assign lowOk = req.lowReq
               && (state_r == CIS_MAIN || state_r == CIS_LOW)
               && atomZero
               && lowEnabled
               && lowStack_r == curStack_r
               && stackRoom && quiet;

  // one take per cycle, nmi first
  assign takeNmi = nmiOk;
  assign takeRt  = rtOk && !nmiOk;
  assign takeLow = lowOk && !nmiOk && !rtOk;
  assign anyTake = takeNmi | takeRt | takeLow;
  assign popEv   = pipe.handlerExit && depth_r != '0 && !settle_r;

  // atomic countdown
  always_comb begin
    atom_nxt = atom_r;
    if (takeNmi) begin
      atom_nxt = '0;
    end else if (pipe.protCallRet) begin
      atom_nxt = '0;
    end else if (pipe.atomicLoad) begin
      // reload even while still running
      atom_nxt = pipe.atomicValue;
    end else if (pipe.packetDone && !atomZero) begin
      // with the loading packet, 256 at most
      atom_nxt = atom_r - 1'b1;
    end
  end

  // low accept enable
  always_comb begin
    low_prio_accept_enable_nxt = low_prio_accept_enable_r;
    if (takeLow) begin
      // the take wins so a handler starts closed
      low_prio_accept_enable_nxt = 1'b0;
    end else if (pipe.disableLowOp) begin
      low_prio_accept_enable_nxt = 1'b0;
    end else if (pipe.enableNestOp) begin
      low_prio_accept_enable_nxt = 1'b1;
    end else if (wrTake && selDsts) begin
      low_prio_accept_enable_nxt = avmWritedata[DECODE_PHASE_STATUS_WORD_LOW_PRIO_ACCEPT_ENABLE_BIT];
    end
  end

  // handler state and priority
  always_comb begin
    state_nxt = state_r;
    prio_nxt  = prio_r;
    if (takeNmi) begin
      state_nxt = CIS_NMI;
      prio_nxt  = '0;
    end else if (takeRt) begin
      state_nxt = CIS_RT;
      prio_nxt  = req.rtPrio;
    end else if (takeLow) begin
      state_nxt = CIS_LOW;
      prio_nxt  = req.lowPrio;
    end else if (popEv) begin
      // resume the interrupted context
      state_nxt = topEntry.state;
      prio_nxt  = topEntry.prio;
    end
  end

  assign pushEntry = '{state: state_r, prio: prio_r};

  // state registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      atom_r   <= '0;
      low_prio_accept_enable_r   <= LOW_PRIO_ACCEPT_ENABLE_RST;
      state_r  <= CIS_MAIN;
      prio_r   <= '0;
      settle_r <= 1'b0;
      ack_r    <= '0;
    end else begin
      atom_r   <= atom_nxt;
      low_prio_accept_enable_r   <= low_prio_accept_enable_nxt;
      state_r  <= state_nxt;
      prio_r   <= prio_nxt;
      // read port lags one cycle behind a stack change
      settle_r <= anyTake | popEv;
      ack_r    <= '{takeNmi: takeNmi, takeRt: takeRt, takeLow: takeLow};
    end
  end

  // nesting depth and per-line counts
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      depth_r  <= '0;
      lowCnt_r <= '0;
      rtCnt_r  <= '0;
      rtPtr_r  <= '0;
      nonmaskable_line_flag_r   <= 1'b0;
    end else if (anyTake) begin
      // flag set as the line is taken
      depth_r <= depth_r + 1'b1;
      // rt and nmi frames go on the rt stack
      if (takeRt || takeNmi) begin
        rtPtr_r <= rtPtr_r + 1'b1;
      end
      if (takeNmi) begin
        nonmaskable_line_flag_r <= 1'b1;
      end
      if (takeRt) begin
        rtCnt_r <= rtCnt_r + 1'b1;
      end
      if (takeLow) begin
        lowCnt_r <= lowCnt_r + 1'b1;
      end
    end else if (popEv) begin
      depth_r <= depth_r - 1'b1;
      // the exiting line is the one now running
      case (state_r)
        CIS_NMI: begin
          nonmaskable_line_flag_r  <= 1'b0;
          rtPtr_r <= rtPtr_r - 1'b1;
        end
        CIS_RT: begin
          // flag holds while others remain
          rtCnt_r <= rtCnt_r - 1'b1;
          rtPtr_r <= rtPtr_r - 1'b1;
        end
        CIS_LOW: begin
          lowCnt_r <= lowCnt_r - 1'b1;
        end
        default: begin
          depth_r <= depth_r;
        end
      endcase
    end
  end

  // saved contexts
  cis_nest_mem u_nest_mem (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wrEn    (anyTake),
    .wrAddr  (depth_r[NADDR_W-1:0]),
    .wrData  (pushEntry),
    .rdAddr  (NADDR_W'(depth_r - 1'b1)),
    .rdData  (topEntry)
  );

  // outputs
  assign avmReaddata    = rdData_r;
  assign avmWaitrequest = waitReq_r;
  assign ack            = ack_r;
  // the aggregator paces rt and low forwarding on this
  assign aggr.handlerState = state_r;
  // kept in its own flop, no adder on the pin
  assign aggr.rtStackPtr   = rtPtr_r;
  assign aggr.warnLevel    = warn_r;
  // one slot kept back for an nmi
  assign aggr.ceilLevel    = CEIL_LEVEL;
  assign aggr.lowStackSel  = lowStack_r;
  assign aggr.currentLink  = curLink_r;
endmodule // cis_ctrl

// ### cis_pkg.sv
package cis_pkg;
  // widths of the fields this block keeps
  localparam int LINK_W = 4;
  localparam int STK_W  = 4;
  localparam int PRIO_W = 8;
  localparam int ATOM_W = 8;
  // nesting stack: one slot per taken interrupt
  localparam int NEST_DEPTH = 16;
  localparam int DEPTH_W    = 5;
  localparam int NADDR_W    = 4;
  localparam logic [DEPTH_W-1:0] NEST_FULL  = 5'h10;
  localparam logic [DEPTH_W-1:0] CEIL_LEVEL = 5'h0f;
  // register byte offsets
  localparam logic [3:0] ADDR_INTERRUPT_STATUS_WORD = 4'h0;
  localparam logic [3:0] ADDR_DECODE_PHASE_STATUS_WORD = 4'h4;
  localparam logic [3:0] ADDR_CFG  = 4'h8;
  localparam logic [3:0] ADDR_STK  = 4'hc;
  // interrupt status word fields
  localparam int INTERRUPT_STATUS_WORD_LINK_LSB  = 27;
  localparam int INTERRUPT_STATUS_WORD_LOW_PRIO_STACK_SELECT_LSB = 21;
  localparam int INTERRUPT_STATUS_WORD_CURSP_LSB = 16;
  localparam int INTERRUPT_STATUS_WORD_ATOM_LSB  = 8;
  localparam int INTERRUPT_STATUS_WORD_NONMASKABLE_LINE_FLAG_BIT  = 2;
  localparam int INTERRUPT_STATUS_WORD_RTF_BIT   = 1;
  localparam int INTERRUPT_STATUS_WORD_LOWF_BIT  = 0;
  // decode phase status word fields
  localparam int DECODE_PHASE_STATUS_WORD_RETURN_ORIGIN_LINK_LSB = 27;
  localparam int DECODE_PHASE_STATUS_WORD_PRIO_LSB  = 19;
  localparam int DECODE_PHASE_STATUS_WORD_STATE_LSB = 17;
  localparam int DECODE_PHASE_STATUS_WORD_LOW_PRIO_ACCEPT_ENABLE_BIT  = 16;
  localparam int DECODE_PHASE_STATUS_WORD_CALLER_ORIGIN_LINK_LSB = 8;
  // configuration and stack words
  localparam int CFG_WARN_LSB  = 0;
  localparam int CFG_LOW_PRIO_STACK_SELECT_LSB = 8;
  localparam int STK_PTR_LSB   = 0;
  localparam int STK_CEIL_LSB  = 8;
  // reset values
  localparam logic              LOW_PRIO_ACCEPT_ENABLE_RST  = 1'b0;
  localparam logic [DEPTH_W-1:0] WARN_RST = 5'h0c;
  localparam logic [STK_W-1:0]  LOW_PRIO_STACK_SELECT_RST = 4'h0;
  localparam logic [LINK_W-1:0] LINK_RST  = 4'h0;

  typedef enum logic [1:0] {
    CIS_MAIN = 2'b00,
    CIS_LOW  = 2'b01,
    CIS_RT   = 2'b10,
    CIS_NMI  = 2'b11
  } cis_state_type;

  // events from the cpu pipeline
  typedef struct packed {
    logic [LINK_W-1:0] d2Link;
    logic [STK_W-1:0]  curStack;
    logic              packetDone;
    logic              atomicLoad;
    logic [ATOM_W-1:0] atomicValue;
    logic              protCallRet;
    logic              protReturn;
    logic [LINK_W-1:0] returnLink;
    logic              callMade;
    logic [LINK_W-1:0] callerLink;
    logic              enableNestOp;
    logic              disableLowOp;
    logic              handlerExit;
  } cis_pipe_type;

  // requests forwarded by the aggregator
  typedef struct packed {
    logic              nmiReq;
    logic              rtReq;
    logic [PRIO_W-1:0] rtPrio;
    logic              lowReq;
    logic [PRIO_W-1:0] lowPrio;
    logic              lowSupervisor;
  } cis_req_type;

  typedef struct packed {
    logic takeNmi;
    logic takeRt;
    logic takeLow;
  } cis_ack_type;

  // state exported to the aggregator
  typedef struct packed {
    cis_state_type      handlerState;
    logic [DEPTH_W-1:0] rtStackPtr;
    logic [DEPTH_W-1:0] warnLevel;
    logic [DEPTH_W-1:0] ceilLevel;
    logic [STK_W-1:0]   lowStackSel;
    logic [LINK_W-1:0]  currentLink;
  } cis_link_type;

  // one saved context on the nesting stack
  typedef struct packed {
    cis_state_type     state;
    logic [PRIO_W-1:0] prio;
  } cis_entry_type;
endpackage

// ### cis_nest_mem.sv
`timescale 1ns/100ps
module cis_nest_mem
  import cis_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               wrEn,
  input  wire logic [NADDR_W-1:0] wrAddr,
  input  cis_entry_type           wrData,
  input  wire logic [NADDR_W-1:0] rdAddr,
  output cis_entry_type           rdData
);
  // saved contexts, no reset needed on the array
  cis_entry_type mem [NEST_DEPTH];
  cis_entry_type rdData_r;

  // write port
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // registered read, old data on a same-address write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_r <= '0;
    end else begin
      rdData_r <= mem[rdAddr];
    end
  end

  assign rdData = rdData_r;
endmodule // cis_nest_mem

// ### cis_ctrl_asserts.sv
`timescale 1ns/100ps
module cis_ctrl_asserts
  import cis_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  avmAddress,
  input wire logic        avmRead,
  input wire logic        avmWrite,
  input wire logic [31:0] avmWritedata,
  input wire logic [31:0] avmReaddata,
  input wire logic        avmWaitrequest,
  input cis_pipe_type     pipe,
  input cis_req_type      req,
  input cis_ack_type      ack,
  input cis_link_type     aggr
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // bus answers after exactly one wait state
  a_wait_one_state: assert property ((avmRead || avmWrite) && avmWaitrequest |=> !avmWaitrequest)
    else $error("waitrequest not low one cycle after request");
  a_wait_back_up: assert property (!avmWaitrequest |=> avmWaitrequest)
    else $error("waitrequest low for more than one cycle");
  // takes are single pulses with a settle cycle
  a_ack_spaced: assert property (ack != '0 |=> ack == '0)
    else $error("ack pulses too close");
  a_low_state: assert property (ack.takeLow |-> aggr.handlerState == CIS_LOW)
    else $error("low take without low state");
  a_rt_state: assert property (ack.takeRt |-> aggr.handlerState == CIS_RT)
    else $error("rt take without rt state");
  a_nmi_state: assert property (ack.takeNmi |-> aggr.handlerState == CIS_NMI)
    else $error("nmi take without nmi state");
  // nothing enters an nmi handler
  a_nmi_closed: assert property (aggr.handlerState == CIS_NMI |=> ack == '0)
    else $error("take inside nmi handler");
  a_low_no_nest: assert property (aggr.handlerState[1] |=> !ack.takeLow)
    else $error("low nested in higher handler");
  a_take_has_req: assert property (ack.takeLow |-> $past(req.lowReq))
    else $error("low take without request");
  a_link_delay: assert property ($past(rst_n) |-> aggr.currentLink == $past(pipe.d2Link))
    else $error("current link does not follow d2 link");
  // rt stack grows by one slot per rt or nmi take
  a_ptr_step: assert property ((ack.takeRt || ack.takeNmi) |->
    aggr.rtStackPtr == $past(aggr.rtStackPtr) + 5'h01)
    else $error("rt stack pointer did not step");

  c_low_take: cover property (ack.takeLow);
  c_nmi_in_rt: cover property (aggr.handlerState == CIS_RT ##1 ack.takeNmi);
  c_rt_in_low: cover property (aggr.handlerState == CIS_LOW ##1 ack.takeRt);
endmodule // cis_ctrl_asserts

bind cis_ctrl cis_ctrl_asserts chk_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .avmAddress(avmAddress), .avmRead(avmRead),
  .avmWrite(avmWrite), .avmWritedata(avmWritedata), .avmReaddata(avmReaddata),
  .avmWaitrequest(avmWaitrequest), .pipe(pipe), .req(req), .ack(ack), .aggr(aggr)
);

// ### cis_aggr_model.sv
`timescale 1ns/100ps
module cis_aggr_model
  import cis_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic [2:0]        raise,
  input wire logic [PRIO_W-1:0] prio,
  input wire logic              sup,
  input cis_ack_type            ack,
  input cis_link_type           aggr,
  output cis_req_type           req
);
  logic              pendNmi_r, pendRt_r, pendLow_r, supLow_r; // pending lines
  logic [PRIO_W-1:0] rtPrio_r, lowPrio_r;                     // priority of the latest raise
  wire               fault = aggr.rtStackPtr >= aggr.ceilLevel;
  wire               inNmi = aggr.handlerState == CIS_NMI;

  // requests held until the cpu acknowledges them
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {pendNmi_r, pendRt_r, pendLow_r, supLow_r, rtPrio_r, lowPrio_r} <= '0;
    end else begin
      if (ack.takeNmi) pendNmi_r <= 1'b0;
      else if (raise[2] || fault) pendNmi_r <= 1'b1;
      if (ack.takeRt) pendRt_r <= 1'b0;
      else if (raise[1]) {pendRt_r, rtPrio_r} <= {1'b1, prio};
      if (ack.takeLow) pendLow_r <= 1'b0;
      else if (raise[0]) {pendLow_r, lowPrio_r, supLow_r} <= {1'b1, prio, sup};
    end
  end

  // rt held back once the stack reaches the warning level
  assign req.nmiReq = pendNmi_r;
  assign req.rtReq = pendRt_r && !inNmi && aggr.rtStackPtr < aggr.warnLevel;
  assign req.lowReq = pendLow_r && !inNmi;
  // released priority lines do not keep the last value
  assign req.rtPrio = req.rtReq ? rtPrio_r : ~rtPrio_r;
  assign req.lowPrio = req.lowReq ? lowPrio_r : ~lowPrio_r;
  assign req.lowSupervisor = req.lowReq ? supLow_r : ~supLow_r;
endmodule // cis_aggr_model

// ### cis_ctrl_tb.sv
`timescale 1ns/100ps
module cis_ctrl_tb
  import cis_pkg::*;
;
  logic         sys_clk, rst_n, avmRead, avmWrite, avmWaitrequest, sup;
  logic [3:0]   avmAddress, lnk, rl, cl, cur; // bus address, expected links
  logic [31:0]  avmWritedata, avmReaddata;
  logic [2:0]   raise;                        // nmi, rt, low raise strobes
  logic [7:0]   prio;
  cis_pipe_type pipe;
  cis_req_type  req;
  cis_ack_type  ack;
  cis_link_type aggr;
  logic [31:0]  expRd[$];                     // notes of expected read data
  logic [2:0]   expAck[$];                    // notes of expected takes
  int           n_mismatch, n_compared;

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  cis_ctrl dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .avmAddress(avmAddress),
    .avmRead(avmRead), .avmWrite(avmWrite), .avmWritedata(avmWritedata),
    .avmReaddata(avmReaddata), .avmWaitrequest(avmWaitrequest), .pipe(pipe),
    .req(req), .ack(ack), .aggr(aggr));
  cis_aggr_model aggr_u (.sys_clk(sys_clk), .rst_n(rst_n), .raise(raise), .prio(prio),
    .sup(sup), .ack(ack), .aggr(aggr), .req(req));

  function automatic logic [31:0] interrupt_status_word(input logic [7:0] at, input logic [2:0] f);
    return {1'b0, lnk, 2'b00, LOW_PRIO_STACK_SELECT_RST, 1'b0, cur, at, 5'h00, f};
  endfunction
  function automatic logic [31:0] decode_phase_status_word(input logic [7:0] p, input cis_state_type s,
                                       input logic e);
    return {1'b0, rl, p, s, e, 4'h0, cl, 8'h00};
  endfunction

  task wrap_up;
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task bad(input string m);
    n_mismatch++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task cmp32(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) bad("read data");
  endtask
  task cmp3(input logic [2:0] g, input logic [2:0] e);
    n_compared++;
    if (g !== e) bad("take pulse");
  endtask

  // watcher: each result appearing takes the oldest note
  always @(posedge sys_clk) begin
    if (avmRead === 1'b1 && avmWaitrequest === 1'b0) begin
      if (expRd.size() == 0) bad("unexpected read");
      else cmp32(avmReaddata, expRd.pop_front());
    end
    if (ack !== 3'b000) begin
      if (expAck.size() == 0) bad("unexpected take");
      else cmp3(ack, expAck.pop_front());
    end
  end

  // one avalon access, held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    avmAddress <= a;
    avmWrite <= w;
    avmRead <= ~w;
    avmWritedata <= d;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avmWaitrequest !== 1'b0 && k < 50);
    avmRead <= 1'b0;
    avmWrite <= 1'b0;
    if (k == 50) begin
      bad("bus timeout");
      wrap_up();
    end
    @(posedge sys_clk);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    expRd.push_back(e);
    bus(1'b0, a, 32'h00000000);
  endtask

  // one-cycle pipeline event, then settle cycles
  task pulse(input int k);
    case (k)
      0: pipe.packetDone <= 1'b1;
      1: pipe.handlerExit <= 1'b1;
      2: pipe.enableNestOp <= 1'b1;
      3: pipe.disableLowOp <= 1'b1;
      4: pipe.protReturn <= 1'b1;
      5: pipe.callMade <= 1'b1;
      7: pipe.protCallRet <= 1'b1;
      default: pipe.atomicLoad <= 1'b1;
    endcase
    @(posedge sys_clk);
    {pipe.packetDone, pipe.handlerExit, pipe.enableNestOp, pipe.disableLowOp} <= 4'h0;
    {pipe.protReturn, pipe.callMade, pipe.atomicLoad, pipe.protCallRet} <= 4'h0;
    repeat (3) @(posedge sys_clk);
  endtask
  // raise a line at the aggregator, noting the take if one is due
  task go(input logic [2:0] r, input logic [7:0] p, input logic s, input logic [2:0] e);
    if (e != 3'b000) expAck.push_back(e);
    raise <= r;
    prio <= p;
    sup <= s;
    @(posedge sys_clk);
    raise <= 3'b000;
    repeat (5) @(posedge sys_clk);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    bad("run timeout");
    wrap_up();
  end

  initial begin
    void'($urandom(32'h4a8bf1fe));
    lnk = 4'($urandom);
    {rl, cl, cur} = 12'h000;
    pipe = '0;
    pipe.d2Link = lnk;
    {raise, prio, sup, avmRead, avmWrite, avmAddress, avmWritedata} = '0;
    rst_n = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(4'h0, interrupt_status_word(8'h00, 3'b000));
    rd(4'h4, decode_phase_status_word(8'h00, CIS_MAIN, 1'b0));
    rd(4'h8, 32'h0000000c);
    rd(4'hc, 32'h00000f00);
    rd(4'h2, 32'h00000000);
    bus(1'b1, 4'h0, 32'hffffffff);
    rd(4'h0, interrupt_status_word(8'h00, 3'b000));
    bus(1'b1, 4'h8, 32'h00000002);
    rd(4'h8, 32'h00000002);
    rl = 4'($urandom);
    cl = 4'($urandom);
    pipe.returnLink <= rl;
    pipe.callerLink <= cl;
    pulse(4);
    pulse(5);
    rd(4'h4, decode_phase_status_word(8'h00, CIS_MAIN, 1'b0));
    go(3'b001, 8'h5a, 1'b0, 3'b000);
    expAck.push_back(3'b001);
    pulse(2);
    rd(4'h4, decode_phase_status_word(8'h5a, CIS_LOW, 1'b0));
    rd(4'h0, interrupt_status_word(8'h00, 3'b001));
    go(3'b010, 8'h33, 1'b0, 3'b010);
    pulse(3);
    go(3'b001, 8'h77, 1'b1, 3'b000);
    go(3'b010, 8'h44, 1'b0, 3'b010);
    go(3'b010, 8'h55, 1'b0, 3'b000);
    go(3'b100, 8'h00, 1'b0, 3'b100);
    rd(4'h4, decode_phase_status_word(8'h00, CIS_NMI, 1'b0));
    rd(4'h0, interrupt_status_word(8'h00, 3'b111));
    pulse(1);
    rd(4'h0, interrupt_status_word(8'h00, 3'b011));
    expAck.push_back(3'b010);
    pulse(1);
    rd(4'h4, decode_phase_status_word(8'h55, CIS_RT, 1'b0));
    pulse(1);
    expAck.push_back(3'b001);
    pulse(1);
    rd(4'h4, decode_phase_status_word(8'h77, CIS_LOW, 1'b0));
    pulse(1);
    pulse(1);
    rd(4'h0, interrupt_status_word(8'h00, 3'b000));
    pipe.atomicValue <= 8'h03;
    pulse(6);
    rd(4'h0, interrupt_status_word(8'h03, 3'b000));
    go(3'b010, 8'h21, 1'b0, 3'b000);
    pulse(0);
    pulse(0);
    rd(4'h0, interrupt_status_word(8'h01, 3'b000));
    expAck.push_back(3'b010);
    pulse(0);
    pulse(1);
    pipe.atomicValue <= 8'hff;
    pulse(6);
    go(3'b100, 8'h00, 1'b0, 3'b100);
    rd(4'h0, interrupt_status_word(8'h00, 3'b100));
    pulse(1);
    pulse(2);
    cur = 4'h1;
    pipe.curStack <= cur;
    go(3'b001, 8'h10, 1'b0, 3'b000);
    rd(4'h0, interrupt_status_word(8'h00, 3'b000));
    expAck.push_back(3'b001);
    cur = 4'h0;
    pipe.curStack <= cur;
    repeat (6) @(posedge sys_clk);
    pulse(1);
    pipe.atomicValue <= 8'h05;
    pulse(6);
    pulse(7);
    rd(4'h0, interrupt_status_word(8'h00, 3'b000));
    bus(1'b1, 4'h4, 32'hffffffff);
    rd(4'h4, decode_phase_status_word(8'h00, CIS_MAIN, 1'b1));
    if (expAck.size() != 0 || expRd.size() != 0) bad("result missing");
    wrap_up();
  end
endmodule // cis_ctrl_tb
